// ===== rtl/ptr_table_read.sv
// How it works
// [RULE1] Address formed from low and high pointers
// [RULE2] Pointer reaches every word of 16K memory
// [RULE3] Every table read loads upper byte latch
// [RULE4] Software may write and read latch
// [RULE5] Table operation takes two instruction cycles
// [RULE6] Software masks interrupts around main-program reads
// [RULE7] Low byte goes to destination register
// [RULE8] Unimplemented upper-byte bits read as zero
// [RULE9] Table read leaves both pointers unchanged
`timescale 1ns/10ps
module ptr_table_read #(
  parameter int PM_ADDR_W = ptr_pkg::PM_ADDR_W,
  parameter int PM_DATA_W = ptr_pkg::PM_DATA_W
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  // core side
  input  wire ptr_pkg::ptr_req_t      i_req,
  output logic                        o_busy,
  output logic                        o_done,
  output ptr_pkg::ptr_dm_wr_t         o_dm_wr,
  // pointer and latch access by software
  input  wire logic                   i_tblp_we,
  input  wire logic                   i_tbhp_we,
  input  wire logic                   i_latch_we,
  input  wire logic [7:0]             i_wdata,
  output logic      [7:0]             o_tblp,
  output logic      [7:0]             o_tbhp,
  output logic      [7:0]             o_table_high_byte_latch,
  // program memory array
  output logic      [PM_ADDR_W-1:0]   o_pm_addr,
  output logic                        o_pm_rd,
  input  wire logic [PM_DATA_W-1:0]   i_pm_data
);

  if (PM_ADDR_W < 9 || PM_ADDR_W > 16) begin : g_bad_addr_w
    $error("ptr_table_read: PM_ADDR_W out of range");
  end
  if (PM_DATA_W <= ptr_pkg::BYTE_W || PM_DATA_W > 16) begin : g_bad_data_w
    $error("ptr_table_read: PM_DATA_W out of range");
  end

  typedef enum logic {
    PTR_IDLE,
    PTR_FETCH
  } ptr_state_t;

  ptr_state_t                          state_r;
  logic [7:0]                          tblp_r;
  logic [7:0]                          tbhp_r;
  logic [7:0]                          latch_r;
  logic [ptr_pkg::DM_ADDR_W-1:0]       dest_r;
  logic [PM_ADDR_W-1:0]                addr_nxt;
  logic [PM_ADDR_W-1:0]                addr_r;
  logic                                start;
  logic [7:0]                          hi_byte;

  ////////////////////////////////////////////////////////////////////////////
  // address forming
  ptr_addr_form #(
    .PM_ADDR_W (PM_ADDR_W)
  ) u_addr (
    .i_tblp (tblp_r),
    .i_tbhp (tbhp_r),
    .o_addr (addr_nxt)                                                // RULE1 RULE2
  );

  assign start = i_req.valid && (i_req.op != ptr_pkg::PTR_OP_NONE) && (state_r == PTR_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing: issue cycle then completion cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= PTR_IDLE;
    end else begin
      case (state_r)
        PTR_IDLE: begin
          if (start) begin
            state_r <= PTR_FETCH;                                      // RULE5
          end
        end
        PTR_FETCH: begin
          state_r <= PTR_IDLE;                                         // RULE5
        end
        default: begin
          state_r <= PTR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_r <= '0;
      dest_r <= '0;
    end else if (start) begin
      addr_r <= addr_nxt;                                              // RULE1
      dest_r <= i_req.dest;
    end
  end

  assign o_pm_addr = addr_r;
  assign o_pm_rd   = (state_r == PTR_FETCH);
  assign o_busy    = start || (state_r == PTR_FETCH);                  // RULE5

  ////////////////////////////////////////////////////////////////////////////
  // pointers: written only by software
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tblp_r <= ptr_pkg::TBLP_RST;
    end else if (i_tblp_we) begin
      tblp_r <= i_wdata;                                               // RULE9
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tbhp_r <= ptr_pkg::TBHP_RST;
    end else if (i_tbhp_we) begin
      tbhp_r <= i_wdata;                                               // RULE9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // high byte latch; hardware load wins over software write
  assign hi_byte = 8'(i_pm_data[PM_DATA_W-1:ptr_pkg::BYTE_W]);         // RULE8

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch_r <= ptr_pkg::LATCH_RST;
    end else if (state_r == PTR_FETCH) begin
      latch_r <= hi_byte;                                              // RULE3 RULE8
    end else if (i_latch_we) begin
      latch_r <= i_wdata;                                              // RULE4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // low byte toward data memory
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dm_wr <= '0;
      o_done  <= 1'b0;
    end else begin
      o_done     <= (state_r == PTR_FETCH);
      o_dm_wr.we <= (state_r == PTR_FETCH);
      if (state_r == PTR_FETCH) begin
        o_dm_wr.addr <= dest_r;                                        // RULE7
        o_dm_wr.data <= i_pm_data[ptr_pkg::BYTE_W-1:0];                // RULE7
      end
    end
  end

  assign o_tblp                  = tblp_r;
  assign o_tbhp                  = tbhp_r;
  assign o_table_high_byte_latch = latch_r;                            // RULE4

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_issue;
    start;
  endsequence

  sequence s_complete;
    ##1 o_pm_rd ##1 (o_done && o_dm_wr.we);
  endsequence

  chk_two_cycle_op: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE5
    s_issue |-> s_complete)
    else $error("table op did not complete in two cycles");

  chk_addr_from_ptrs: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE1
    start |=> (o_pm_addr == $past(addr_nxt)))
    else $error("fetch address not taken from pointers");

  chk_addr_full_span: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE2
    start |=> (o_pm_addr == PM_ADDR_W'({$past(tbhp_r), $past(tblp_r)})))
    else $error("fetch address does not span all pointer bits");

  chk_latch_loads: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE3
    o_pm_rd |=> (o_table_high_byte_latch == $past(hi_byte)))
    else $error("high byte latch not loaded by table read");

  chk_latch_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE4
    (i_latch_we && !o_pm_rd) |=> (o_table_high_byte_latch == $past(i_wdata)))
    else $error("software write to latch lost");

  chk_latch_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE4
    (!o_pm_rd && !i_latch_we) |=> $stable(o_table_high_byte_latch))
    else $error("latch changed with no load or write");

  chk_low_byte_dest: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE7
    o_pm_rd |=> (o_dm_wr.we && o_dm_wr.addr == $past(dest_r)
                 && o_dm_wr.data == $past(i_pm_data[7:0])))
    else $error("low byte not written to destination");

  chk_dm_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE7
    !o_pm_rd |=> !o_dm_wr.we)
    else $error("data memory written outside a table read");

  chk_unused_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE8
    o_pm_rd |=> (o_table_high_byte_latch == 8'($past(i_pm_data) >> ptr_pkg::BYTE_W)))
    else $error("unimplemented latch bits not zero");

  chk_ptr_stable: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE9
    (o_busy && !i_tblp_we && !i_tbhp_we) |=> ($stable(o_tblp) && $stable(o_tbhp)))
    else $error("table read altered pointers");

  chk_ptr_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE9
    i_tblp_we |=> (o_tblp == $past(i_wdata)))
    else $error("software pointer write lost");

  chk_busy_fetch: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE5
    o_pm_rd |-> o_busy)
    else $error("busy low during fetch cycle");

  chk_none_ignored: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE5
    (i_req.valid && i_req.op == ptr_pkg::PTR_OP_NONE) |=> !o_pm_rd)
    else $error("empty request started a fetch");

  chk_done_single: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE5
    o_done |=> !o_done)
    else $error("done pulse longer than one cycle");

endmodule : ptr_table_read

// ===== rtl/ptr_pkg.sv
package ptr_pkg;
  // program memory geometry
  localparam int          PM_ADDR_W      = 14;           // 16K words
  localparam int          PM_DATA_W      = 16;
  localparam int          BYTE_W         = 8;
  localparam int          DM_ADDR_W      = 8;
  localparam int          TBLP_HI_POS    = 8;            // high pointer sits above low pointer
  localparam int          TBHP_W         = PM_ADDR_W - TBLP_HI_POS;
  localparam logic [7:0]  TBLP_RST       = 8'h00;
  localparam logic [7:0]  TBHP_RST       = 8'h00;
  localparam logic [7:0]  LATCH_RST      = 8'h00;
  localparam int          TABLE_CYCLES   = 2;            // instruction cycles per table op
  localparam int          FETCH_LATENCY  = 1;            // array read latency in cycles

  typedef enum logic [1:0] {
    PTR_OP_NONE,
    PTR_OP_SHORT,
    PTR_OP_LONG
  } ptr_op_t;

  // request from the core
  typedef struct packed {
    logic                 valid;
    ptr_op_t              op;
    logic [DM_ADDR_W-1:0] dest;
  } ptr_req_t;

  // data memory write toward the core
  typedef struct packed {
    logic                 we;
    logic [DM_ADDR_W-1:0] addr;
    logic [BYTE_W-1:0]    data;
  } ptr_dm_wr_t;
endpackage : ptr_pkg

// ===== rtl/ptr_addr_form.sv
`timescale 1ns/10ps
module ptr_addr_form #(
  parameter int PM_ADDR_W = 14
) (
  input  wire logic [7:0]           i_tblp,
  input  wire logic [7:0]           i_tbhp,
  output logic      [PM_ADDR_W-1:0] o_addr
);
  if (PM_ADDR_W <= 8 || PM_ADDR_W > 16) begin : g_bad_addr_w
    $error("ptr_addr_form: PM_ADDR_W out of range");
  end
  // high pointer supplies bits above the low byte; excess high bits ignored
  logic [15:0] full_addr;
  assign full_addr = {i_tbhp, i_tblp};
  assign o_addr    = full_addr[PM_ADDR_W-1:0];
endmodule : ptr_addr_form

// ===== testbench/ptr_pm_model.sv
`timescale 1ns/10ps
module ptr_pm_model (
  input  wire logic                          i_clk,
  input  wire logic                          i_rd,
  input  wire logic [ptr_pkg::PM_ADDR_W-1:0] i_addr,
  output logic      [ptr_pkg::PM_DATA_W-1:0] o_data
);
  logic [ptr_pkg::PM_DATA_W-1:0] word;
  logic [ptr_pkg::PM_DATA_W-1:0] last_r = '0;
  // contents derived from the address, distinct in both bytes
  assign word = {i_addr[7:0] ^ 8'ha5, i_addr[13:6] ^ 8'h3c};
  always_ff @(posedge i_clk) begin
    if (i_rd) last_r <= word;
  end
  // no stale word outside a fetch
  assign o_data = i_rd ? word : ~last_r;
endmodule : ptr_pm_model

// ===== testbench/ptr_table_read_tb.sv
`timescale 1ns/10ps
module ptr_table_read_tb;
  logic                i_clk = 1'b0;
  logic                i_rst_n = 1'b0;
  ptr_pkg::ptr_req_t   i_req;
  logic                o_busy;
  logic                o_done;
  ptr_pkg::ptr_dm_wr_t o_dm_wr;
  logic [2:0]          we;
  logic [7:0]          i_wdata;
  logic [7:0]          o_tblp;
  logic [7:0]          o_tbhp;
  logic [7:0]          o_latch;
  logic [13:0]         o_pm_addr;
  logic                o_pm_rd;
  logic [15:0]         i_pm_data;
  logic [7:0]          tl;
  logic [7:0]          th;
  int                  err_count = 0;
  int                  num_checks = 0;

  initial begin
    forever #12.5 i_clk = ~i_clk;
  end

  ptr_table_read DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req), .o_busy(o_busy), .o_done(o_done),
    .o_dm_wr(o_dm_wr), .i_tblp_we(we[0]), .i_tbhp_we(we[1]), .i_latch_we(we[2]), .i_wdata(i_wdata),
    .o_tblp(o_tblp), .o_tbhp(o_tbhp), .o_table_high_byte_latch(o_latch), .o_pm_addr(o_pm_addr),
    .o_pm_rd(o_pm_rd), .i_pm_data(i_pm_data));
  ptr_pm_model u_pm (.i_clk(i_clk), .i_rd(o_pm_rd), .i_addr(o_pm_addr), .o_data(i_pm_data));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_word(logic [13:0] a);
    return {a[7:0] ^ 8'ha5, a[13:6] ^ 8'h3c};
  endfunction : exp_word

  task automatic stop_test();
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(int sel, logic [7:0] v);
    @(negedge i_clk);
    i_wdata = v;
    we      = 3'b001 << sel;
    @(negedge i_clk);
    we      = 3'b000;
  endtask : wr

  task automatic read_op(ptr_pkg::ptr_op_t op, logic [7:0] dest);
    logic [15:0] w;
    w = exp_word({th[5:0], tl});
    @(negedge i_clk);
    i_req = '{1'b1, op, dest};
    @(negedge i_clk);
    i_req = '0;
    chk(16'(o_pm_rd), 16'h1);
    chk(16'(o_pm_addr), {2'h0, th[5:0], tl});
    chk(16'(o_done), 16'h0);
    chk(16'(o_busy), 16'h1);
    @(negedge i_clk);
    chk(16'(o_busy), 16'h0);
    chk({o_done, o_dm_wr.we}, 16'h3);
    chk(16'(o_dm_wr.addr), 16'(dest));
    chk(16'(o_dm_wr.data), 16'(w[7:0]));
    chk(16'(o_latch), 16'(w[15:8]));
    chk({o_tbhp, o_tblp}, {th, tl});
  endtask : read_op

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    i_req   = '0;
    we      = 3'b000;
    i_wdata = 8'h00;
    void'($urandom(32'h9f9e));
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_n = 1'b1;
    chk({o_tbhp, o_tblp}, 16'h0);
    chk(16'(o_latch), 16'h0);
    for (int n = 0; n < 40; n++) begin
      tl = (n == 0) ? 8'hff : (n == 1) ? 8'h00 : 8'($urandom);
      th = (n == 0) ? 8'h3f : (n == 1) ? 8'h00 : 8'($urandom);
      wr(0, tl);
      wr(1, th);
      read_op((n % 2) ? ptr_pkg::PTR_OP_LONG : ptr_pkg::PTR_OP_SHORT, 8'($urandom));
    end
    wr(2, 8'h5e);
    chk(16'(o_latch), 16'h005e);
    @(negedge i_clk);
    i_req = '{1'b1, ptr_pkg::PTR_OP_NONE, 8'h12};
    repeat (3) begin
      @(negedge i_clk);
      chk({o_pm_rd, o_busy, o_done, o_dm_wr.we, o_latch}, 16'h005e);
    end
    i_req = '0;
    stop_test();
  end

  initial begin
    #(25 * 4000);
    err_count++;
    stop_test();
  end
endmodule : ptr_table_read_tb
